// file: rtl/lpc_cfg_pkg.sv
// Constants for the bridge configuration register bank
// Functional notes
// R1 - Multiplier field bits 11:8 is writable and resets to 1111 by strap or RTC reset
// R2 - Multiplier field lives in the RTC well, independent of core reset
// R3 - Power-good rise samples audio serial out; high sets safe bit 2, forces multiplier
// R4 - Bit 1 disables watchdog reboot; set by speaker low at power-good or software
// R5 - Upper lock bit 4 blocks writes to upper bank bytes 38h-3Fh
// R6 - Lower lock bit 3 blocks writes to lower bank bytes 38h-3Fh
// R7 - Both lock bits are write-once, cleared only by hardware reset
// R8 - Bit 2 of RAM config enables access to upper RAM bank
// R9 - RAM config is 8 bits at D8h, reset 00h, bits 7:5 and 1:0 reserved
// R10 - Bits 6:4 select port B base from eight-entry table
// R11 - Bits 2:0 select port A base from the same table
// R12 - Port decode register is 8 bits at E0h, reset 00h, bits 7 and 3 reserved
// R13 - Port ranges are forwarded only when their enable input is set
// R14 - Reserved bits read zero and ignore writes
`default_nettype none
package lpc_cfg_pkg;
    localparam logic [7:0] OFF_GEN_STA0 = 8'hd4;
    localparam logic [7:0] OFF_GEN_STA1 = 8'hd5;
    localparam logic [7:0] OFF_RAM_CONFIG = 8'hd8;
    localparam logic [7:0] OFF_PORT_DECODE = 8'he0;
    localparam logic [7:0] RAM_CONFIG_RESET = 8'h00;
    localparam logic [7:0] PORT_DECODE_RESET = 8'h00;
    localparam logic [3:0] MULT_RESET = 4'hf;
    localparam logic [7:0] RAM_CONFIG_MASK = 8'h1c;
    localparam logic [7:0] PORT_DECODE_MASK = 8'h77;
    localparam logic [7:0] LOCK_BITS_MASK = 8'h18;
    localparam logic [15:0] PORT_BASE_RESET = 16'h03f8;
    localparam logic [2:0] PIN_SYNC_RESET = 3'h4;
    localparam int RTC_ULOCK_BIT = 4;
    localparam int RTC_LLOCK_BIT = 3;
    localparam int RTC_UEN_BIT = 2;
    localparam int SAFE_BIT = 2;
    localparam int NO_REBOOT_BIT = 1;
    localparam logic [6:0] LOCK_LO = 7'h38;
    localparam logic [6:0] LOCK_HI = 7'h3f;

    function automatic logic [15:0] com_base(input logic [2:0] sel);
        logic [15:0] b;
        b = 16'h03f8;
        unique case (sel)
            3'h0: b = 16'h03f8;
            3'h1: b = 16'h02f8;
            3'h2: b = 16'h0220;
            3'h3: b = 16'h0228;
            3'h4: b = 16'h0238;
            3'h5: b = 16'h02e8;
            3'h6: b = 16'h0338;
            3'h7: b = 16'h03e8;
        endcase
        return b;
    endfunction
endpackage
`default_nettype wire

// file: rtl/rtc_well_mult.sv
// Multiplier field held in the battery-backed well
`default_nettype none
module rtc_well_mult
    import lpc_cfg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rtc_resetn,
    input wire logic i_force,
    input wire logic i_we,
    input wire logic [3:0] i_wdata,
    output logic [3:0] o_mult
);
    logic [3:0] mult_reg;
    logic [3:0] mult_next;

    assign mult_next = i_force ? MULT_RESET : (i_we ? i_wdata : mult_reg); // R1 R3
    // Own reset only, core reset does not reach it
    always_ff @(posedge i_clk or negedge i_rtc_resetn) begin // R2
        if (!i_rtc_resetn) begin
            mult_reg <= MULT_RESET; // R1
        end else begin
            mult_reg <= mult_next;
        end
    end
    assign o_mult = mult_reg;

    a_rtc_force: assert property (@(posedge i_clk) disable iff (!i_rtc_resetn)
        i_force |=> mult_reg == MULT_RESET) else $error("multiplier not forced"); // R3
    a_rtc_write: assert property (@(posedge i_clk) disable iff (!i_rtc_resetn)
        i_we && !i_force |=> mult_reg == $past(i_wdata)) else $error("multiplier write lost"); // R1
endmodule
`default_nettype wire

// file: rtl/lpc_bridge_config_regs.sv
// Bridge configuration registers: general status tail, RAM config, port decode
`default_nettype none
module lpc_bridge_config_regs
    import lpc_cfg_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_rtc_well_reset_n,
    input wire logic i_power_good,
    input wire logic i_audio_link_serial_out,
    input wire logic i_speaker_pin,
    input wire logic i_cfg_wr,
    input wire logic i_cfg_rd,
    input wire logic [7:0] i_cfg_addr,
    input wire logic [7:0] i_cfg_wdata,
    output logic [7:0] o_cfg_rdata,
    input wire logic i_port_a_forward_enable,
    input wire logic i_port_b_forward_enable,
    input wire logic i_ram_wr,
    input wire logic i_ram_upper,
    input wire logic [6:0] i_ram_addr,
    output logic o_ram_wr_allow,
    output logic o_ram_access_allow,
    output logic [3:0] o_cpu_multiplier_field,
    output logic o_watchdog_no_reboot,
    output logic [15:0] o_serial_port_a_base,
    output logic o_serial_port_a_en,
    output logic [15:0] o_serial_port_b_base,
    output logic o_serial_port_b_en
);
    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [2:0] sync1_reg;
    logic [2:0] sync2_reg;
    logic pg_last_reg;
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            // Power-good idles high, so a core reset must not fake a rise
            sync1_reg <= PIN_SYNC_RESET;
            sync2_reg <= PIN_SYNC_RESET;
            pg_last_reg <= 1'b1;
        end else begin
            sync1_reg <= {i_power_good, i_audio_link_serial_out, i_speaker_pin};
            sync2_reg <= sync1_reg;
            pg_last_reg <= sync2_reg[2];
        end
    end
    wire pg_rise = sync2_reg[2] && !pg_last_reg;
    wire sdout_s = sync2_reg[1];
    wire speaker_s = sync2_reg[0];

    // ------------------------------------------------------------
    // Register decode
    // ------------------------------------------------------------
    wire wr_sta1 = i_cfg_wr && (i_cfg_addr == OFF_GEN_STA1);
    wire wr_sta0 = i_cfg_wr && (i_cfg_addr == OFF_GEN_STA0);
    wire wr_rtc = i_cfg_wr && (i_cfg_addr == OFF_RAM_CONFIG);
    wire wr_com = i_cfg_wr && (i_cfg_addr == OFF_PORT_DECODE);

    // ------------------------------------------------------------
    // General status tail
    // ------------------------------------------------------------
    logic safe_reg;
    logic safe_next;
    logic no_reboot_reg;
    logic no_reboot_next;
    logic [3:0] mult;
    wire mult_force = pg_rise && sdout_s; // R3
    assign safe_next = pg_rise ? sdout_s : safe_reg; // R3
    assign no_reboot_next = no_reboot_reg || (pg_rise && !speaker_s) // R4
        || (wr_sta0 && i_cfg_wdata[NO_REBOOT_BIT]); // R4

    rtc_well_mult u_mult (
        .i_clk(i_clk),
        .i_rtc_resetn(i_rtc_well_reset_n),
        .i_force(mult_force),
        .i_we(wr_sta1),
        .i_wdata(i_cfg_wdata[3:0]),
        .o_mult(mult)
    );

    // ------------------------------------------------------------
    // RAM config and port decode
    // ------------------------------------------------------------
    logic [7:0] rtc_ram_config_reg;
    logic [7:0] rtc_ram_config_next;
    logic [7:0] serial_port_decode_ranges_reg;
    logic [7:0] serial_port_decode_ranges_next;
    // Lock bits may only go from 0 to 1
    wire [7:0] lock_keep = rtc_ram_config_reg & LOCK_BITS_MASK; // R7
    assign rtc_ram_config_next = wr_rtc ?
        (((i_cfg_wdata & RAM_CONFIG_MASK) | lock_keep) & RAM_CONFIG_MASK) // R7 R14
        : rtc_ram_config_reg;
    assign serial_port_decode_ranges_next = wr_com ?
        (i_cfg_wdata & PORT_DECODE_MASK) : serial_port_decode_ranges_reg; // R12 R14

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rtc_ram_config_reg <= RAM_CONFIG_RESET; // R9 R7
            serial_port_decode_ranges_reg <= PORT_DECODE_RESET; // R12
            safe_reg <= 1'b0;
            no_reboot_reg <= 1'b0;
        end else begin
            rtc_ram_config_reg <= rtc_ram_config_next;
            serial_port_decode_ranges_reg <= serial_port_decode_ranges_next;
            safe_reg <= safe_next;
            no_reboot_reg <= no_reboot_next;
        end
    end

    // ------------------------------------------------------------
    // RAM gating
    // ------------------------------------------------------------
    wire upper_bank_lock = rtc_ram_config_reg[RTC_ULOCK_BIT];
    wire lower_bank_lock = rtc_ram_config_reg[RTC_LLOCK_BIT];
    wire upper_bank_enable = rtc_ram_config_reg[RTC_UEN_BIT];
    wire in_lock_range = (i_ram_addr >= LOCK_LO) && (i_ram_addr <= LOCK_HI);
    wire bank_locked = in_lock_range && (i_ram_upper ? upper_bank_lock : lower_bank_lock); // R5 R6
    wire access_ok = !i_ram_upper || upper_bank_enable; // R8
    wire wr_ok = access_ok && !bank_locked && i_ram_wr; // R5 R6

    // ------------------------------------------------------------
    // Read data and outputs
    // ------------------------------------------------------------
    logic [7:0] rdata_next;
    assign rdata_next = !i_cfg_rd ? 8'h00 :
        (i_cfg_addr == OFF_GEN_STA0) ?
            {5'h00, safe_reg, no_reboot_reg, 1'b0} : // R14
        (i_cfg_addr == OFF_GEN_STA1) ? {4'h0, mult} :
        (i_cfg_addr == OFF_RAM_CONFIG) ? rtc_ram_config_reg :
        (i_cfg_addr == OFF_PORT_DECODE) ? serial_port_decode_ranges_reg : 8'h00;

    wire [2:0] sel_a = serial_port_decode_ranges_reg[2:0];
    wire [2:0] sel_b = serial_port_decode_ranges_reg[6:4];

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_cfg_rdata <= 8'h00;
            o_ram_wr_allow <= 1'b0;
            o_ram_access_allow <= 1'b0;
            o_cpu_multiplier_field <= MULT_RESET;
            o_watchdog_no_reboot <= 1'b0;
            o_serial_port_a_base <= PORT_BASE_RESET;
            o_serial_port_b_base <= PORT_BASE_RESET;
            o_serial_port_a_en <= 1'b0;
            o_serial_port_b_en <= 1'b0;
        end else begin
            o_cfg_rdata <= rdata_next;
            o_ram_wr_allow <= wr_ok;
            o_ram_access_allow <= access_ok;
            o_cpu_multiplier_field <= mult;
            o_watchdog_no_reboot <= no_reboot_reg; // R4
            o_serial_port_a_base <= com_base(sel_a); // R11
            o_serial_port_b_base <= com_base(sel_b); // R10
            o_serial_port_a_en <= i_port_a_forward_enable; // R13
            o_serial_port_b_en <= i_port_b_forward_enable; // R13
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_lock_sticky: assert property (@(posedge i_clk) disable iff (!i_resetn)
        $rose(upper_bank_lock) |=> upper_bank_lock [*8]) else $error("lock cleared"); // R7
    a_upper_lock_wr: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ram_wr && i_ram_upper && in_lock_range && upper_bank_lock |=> !o_ram_wr_allow)
        else $error("upper locked write passed"); // R5
    a_lower_lock_wr: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ram_wr && !i_ram_upper && in_lock_range && lower_bank_lock |=> !o_ram_wr_allow)
        else $error("lower locked write passed"); // R6
    a_upper_enable: assert property (@(posedge i_clk) disable iff (!i_resetn)
        i_ram_upper && !upper_bank_enable |=> !o_ram_access_allow)
        else $error("upper bank reached while disabled"); // R8
    a_safe_sample: assert property (@(posedge i_clk) disable iff (!i_resetn)
        pg_rise |=> safe_reg == $past(sdout_s)) else $error("safe bit wrong"); // R3
    a_reboot_set: assert property (@(posedge i_clk) disable iff (!i_resetn)
        pg_rise && !speaker_s |=> ##1 o_watchdog_no_reboot) else $error("no reboot not set"); // R4
    a_rsvd_zero: assert property (@(posedge i_clk) disable iff (!i_resetn)
        (rtc_ram_config_reg & 8'he3) == 8'h00 && serial_port_decode_ranges_reg[7] == 1'b0
        && serial_port_decode_ranges_reg[3] == 1'b0) else $error("reserved bit set"); // R14
    a_port_b_base: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_com && i_cfg_wdata[6:4] == 3'h7 |=> ##1 o_serial_port_b_base == 16'h03e8)
        else $error("port b base wrong"); // R10
    a_port_a_base: assert property (@(posedge i_clk) disable iff (!i_resetn)
        wr_com && i_cfg_wdata[2:0] == 3'h2 |=> ##1 o_serial_port_a_base == 16'h0220)
        else $error("port a base wrong"); // R11
    c_pg_rise: cover property (@(posedge i_clk) disable iff (!i_resetn) pg_rise && sdout_s);
    c_lock_wr: cover property (@(posedge i_clk) disable iff (!i_resetn) wr_rtc && upper_bank_lock);
    c_com_wr: cover property (@(posedge i_clk) disable iff (!i_resetn) wr_com);
endmodule
`default_nettype wire

// file: test/lpc_bridge_config_regs_bench.sv
// Self-checking bench for the bridge configuration register bank
`default_nettype none
module lpc_bridge_config_regs_bench import lpc_cfg_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, resetn, rtcn, pg, aud, spk, wr, rd, pa_en, pb_en, ram_wr, ram_up;
    logic [7:0] addr, wdata, rdata, d;
    logic [6:0] ram_addr;
    logic wr_ok, acc_ok, no_reboot, a_en, b_en;
    logic [3:0] mult;
    logic [15:0] a_base, b_base;
    int err_total = 0;
    int compares = 0;
    logic [15:0] bases [8] = '{16'h03f8, 16'h02f8, 16'h0220, 16'h0228,
                               16'h0238, 16'h02e8, 16'h0338, 16'h03e8};
    lpc_bridge_config_regs u_lpc_bridge_config_regs (.i_clk(clk), .i_resetn(resetn),
        .i_rtc_well_reset_n(rtcn), .i_power_good(pg), .i_audio_link_serial_out(aud),
        .i_speaker_pin(spk), .i_cfg_wr(wr), .i_cfg_rd(rd), .i_cfg_addr(addr),
        .i_cfg_wdata(wdata), .o_cfg_rdata(rdata), .i_port_a_forward_enable(pa_en),
        .i_port_b_forward_enable(pb_en), .i_ram_wr(ram_wr), .i_ram_upper(ram_up),
        .i_ram_addr(ram_addr), .o_ram_wr_allow(wr_ok), .o_ram_access_allow(acc_ok),
        .o_cpu_multiplier_field(mult), .o_watchdog_no_reboot(no_reboot),
        .o_serial_port_a_base(a_base), .o_serial_port_a_en(a_en),
        .o_serial_port_b_base(b_base), .o_serial_port_b_en(b_en));
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("mismatch %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic core_reset();
        @(posedge clk);
        resetn <= 1'b0;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        cyc(1);
    endtask
    task automatic cfg_write(input logic [7:0] a, input logic [7:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic cfg_read(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("cfg_rdata", {8'h0, rdata}, {8'h0, exp});
    endtask
    task automatic ram_chk(input logic up, input logic [6:0] a, input logic ew, input logic ea);
        @(posedge clk);
        ram_wr <= 1'b1;
        ram_up <= up;
        ram_addr <= a;
        @(posedge clk);
        ram_wr <= 1'b0;
        #1;
        chk("ram_wr_allow", {15'h0, wr_ok}, {15'h0, ew});
        chk("ram_access_allow", {15'h0, acc_ok}, {15'h0, ea});
    endtask
    // ---------------------------------------------------------------
    // Scenarios
    // ---------------------------------------------------------------
    task automatic t_reset_values();
        cfg_read(OFF_RAM_CONFIG, 8'h00);
        cfg_read(OFF_PORT_DECODE, 8'h00);
        chk("mult", {12'h0, mult}, 16'h000f);
        chk("a_base", a_base, 16'h03f8);
        chk("b_base", b_base, 16'h03f8);
    endtask
    task automatic t_port_decode();
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            pa_en <= i[0];
            pb_en <= ~i[0];
            cfg_write(OFF_PORT_DECODE, {1'b1, 3'(i), 1'b1, 3'(7 - i)});
            cfg_read(OFF_PORT_DECODE, {1'b0, 3'(i), 1'b0, 3'(7 - i)});
            chk("b_base", b_base, bases[i]);
            chk("a_base", a_base, bases[7 - i]);
            chk("en", {14'h0, a_en, b_en}, {14'h0, i[0], ~i[0]});
        end
    endtask
    task automatic t_ram_lock();
        ram_chk(1'b1, 7'h10, 1'b0, 1'b0);
        cfg_write(OFF_RAM_CONFIG, 8'h04);
        ram_chk(1'b1, 7'h10, 1'b1, 1'b1);
        ram_chk(1'b0, 7'h38, 1'b1, 1'b1);
        cfg_write(OFF_RAM_CONFIG, 8'hff);
        cfg_read(OFF_RAM_CONFIG, 8'h1c);
        ram_chk(1'b0, 7'h38, 1'b0, 1'b1);
        ram_chk(1'b0, 7'h3f, 1'b0, 1'b1);
        ram_chk(1'b0, 7'h37, 1'b1, 1'b1);
        ram_chk(1'b1, 7'h38, 1'b0, 1'b1);
        ram_chk(1'b1, 7'h3f, 1'b0, 1'b1);
        ram_chk(1'b1, 7'h40, 1'b1, 1'b1);
        cfg_write(OFF_RAM_CONFIG, 8'h00);
        cfg_read(OFF_RAM_CONFIG, 8'h18);
        ram_chk(1'b1, 7'h10, 1'b0, 1'b0);
        core_reset();
        cfg_read(OFF_RAM_CONFIG, 8'h00);
        ram_chk(1'b0, 7'h3a, 1'b1, 1'b1);
    endtask
    task automatic t_straps();
        cfg_write(OFF_GEN_STA1, 8'h05);
        cfg_read(OFF_GEN_STA1, 8'h05);
        chk("mult", {12'h0, mult}, 16'h0005);
        @(posedge clk);
        aud <= 1'b1;
        spk <= 1'b0;
        repeat (4) @(posedge clk);
        pg <= 1'b1;
        cyc(8);
        cfg_read(OFF_GEN_STA0, 8'h06);
        chk("mult", {12'h0, mult}, 16'h000f);
        chk("no_reboot", {15'h0, no_reboot}, 16'h0001);
        @(posedge clk);
        pg <= 1'b0;
        aud <= 1'b0;
        spk <= 1'b1;
        cyc(4);
        cfg_write(OFF_GEN_STA1, 8'h0a);
        pg <= 1'b1;
        cyc(8);
        cfg_read(OFF_GEN_STA0, 8'h02);
        chk("mult", {12'h0, mult}, 16'h000a);
        // Straps set while power-good stays high: a core reset must not resample them
        @(posedge clk);
        aud <= 1'b1;
        spk <= 1'b0;
        core_reset();
        cyc(4);
        chk("mult", {12'h0, mult}, 16'h000a);
        chk("no_reboot", {15'h0, no_reboot}, 16'h0000);
        cfg_read(OFF_GEN_STA0, 8'h00);
        cfg_write(OFF_GEN_STA0, 8'h06);
        cfg_read(OFF_GEN_STA0, 8'h02);
        chk("no_reboot", {15'h0, no_reboot}, 16'h0001);
        @(posedge clk);
        rtcn <= 1'b0;
        cyc(2);
        chk("mult", {12'h0, mult}, 16'h000f);
        @(posedge clk);
        rtcn <= 1'b1;
    endtask
    // ---------------------------------------------------------------
    // Clock, sequence and verdict
    // ---------------------------------------------------------------
    task automatic print_verdict();
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        {resetn, rtcn, pg, aud, spk, wr, rd, pa_en, pb_en, ram_wr, ram_up} = '0;
        spk = 1'b1;
        addr = 8'h00;
        wdata = 8'h00;
        ram_addr = 7'h00;
        repeat (6) @(posedge clk);
        resetn <= 1'b1;
        rtcn <= 1'b1;
        cyc(1);
        t_reset_values();
        t_port_decode();
        t_ram_lock();
        t_straps();
        print_verdict();
    end
endmodule
`default_nettype wire
